// File: dvr_checker.sv
// Port assertions for the volume ramp block
`timescale 1ns/10ps
`default_nettype none
module dvr_checker (
    // Clock, reset, enable
    input wire logic       sys_clk,
    input wire logic       nrst,
    input wire logic       clk_en,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Ramp inputs
    input wire logic       sample_tick,
    input wire logic       emergency_req,
    // Gain and DSP outputs
    input wire logic [7:0] gain_code_left,
    input wire logic [7:0] gain_code_right,
    input wire logic [8:0] gain_half_db,
    input wire logic       output_muted,
    input wire logic       ramp_busy,
    input wire logic [1:0] processing_rate_select,
    input wire logic       rom_coefficient_select
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic       emg_q; // Fault request one cycle back
    logic       calm;  // No write and no fault change last cycle
    logic [7:0] wd1;   // Write data one cycle back
    logic [7:0] wd2;   // Write data two cycles back
    // History of target disturbances and write data
    always @(posedge sys_clk) begin
        emg_q <= emergency_req;
        calm  <= !reg_wr && (emergency_req == emg_q);
        wd1   <= reg_wdata;
        wd2   <= wd1;
    end
    a_channels_match: assert property (gain_code_left == gain_code_right)
        else $error("left and right gain differ");
    a_half_db_map: assert property (gain_half_db == 9'h030 - {1'b0, gain_code_left})
        else $error("half dB gain off its code");
    a_mute_flag: assert property (output_muted == (gain_code_left == 8'hff))
        else $error("mute flag off the gain code");
    a_idle_gain_holds: assert property (!ramp_busy && calm && !reg_wr && emergency_req == emg_q
        |=> $stable(gain_code_left)) else $error("gain moved while settled");
    a_rate_follows: assert property (clk_en && reg_wr && reg_addr == 8'h46 ##1 clk_en && !reg_wr
        |=> processing_rate_select == wd2[4:3]) else $error("rate select not written value");
    a_rom_follows: assert property (clk_en && reg_wr && reg_addr == 8'h46 ##1 clk_en && !reg_wr
        |=> rom_coefficient_select == wd2[0]) else $error("coefficient select not written value");
    a_unmapped_zero: assert property (clk_en && reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_frozen_hold: assert property (!clk_en |=> $stable(gain_code_left) && $stable(reg_rdata))
        else $error("state moved while disabled");
endmodule
bind dvr_volume_ctrl dvr_checker u_chk (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sample_tick(sample_tick), .emergency_req(emergency_req), .gain_code_left(gain_code_left),
    .gain_code_right(gain_code_right), .gain_half_db(gain_half_db), .output_muted(output_muted),
    .ramp_busy(ramp_busy), .processing_rate_select(processing_rate_select),
    .rom_coefficient_select(rom_coefficient_select));
`default_nettype wire

// File: dvr_map.vh
// Register offsets, field positions, reset values and gain codes of the volume ramp block
`ifndef DVR_MAP_VH
`define DVR_MAP_VH

// Register offsets on the control port
`define DVR_OFF_DSP_CTRL        8'h46
`define DVR_OFF_GAIN_LEVEL      8'h4c
`define DVR_OFF_APPLIED_GAIN    8'h4d
`define DVR_OFF_NORMAL_RAMP     8'h4e
`define DVR_OFF_EMERG_RAMP      8'h4f

// Reset values
`define DVR_RST_DSP_CTRL        8'h01
`define DVR_RST_GAIN_LEVEL      8'h30
`define DVR_RST_NORMAL_RAMP     8'h33
`define DVR_RST_EMERG_RAMP      8'h30
`define DVR_RST_DSP_RSV         3'h0
`define DVR_RST_DSP_RATE        2'h0
`define DVR_RST_DSP_ROM         1'b1

// Field positions, processing and coefficient control
`define DVR_DSP_RSV_HI          7
`define DVR_DSP_RSV_LO          5
`define DVR_DSP_RATE_HI         4
`define DVR_DSP_RATE_LO         3
`define DVR_DSP_ROM_BIT         0

// Field positions, ramp configuration registers
`define DVR_DOWN_RATE_HI        7
`define DVR_DOWN_RATE_LO        6
`define DVR_DOWN_INC_HI         5
`define DVR_DOWN_INC_LO         4
`define DVR_UP_RATE_HI          3
`define DVR_UP_RATE_LO          2
`define DVR_UP_INC_HI           1
`define DVR_UP_INC_LO           0
`define DVR_EMERG_RSV_HI        3
`define DVR_EMERG_RSV_LO        0

// Gain codes and arithmetic
`define DVR_CODE_UNITY          8'h30
`define DVR_CODE_MUTE           8'hff
`define DVR_UNITY_HALF_DB       9'h030

// Rate codes
`define DVR_RATE_EVERY1         2'h0
`define DVR_RATE_EVERY2         2'h1
`define DVR_RATE_EVERY4         2'h2
`define DVR_RATE_INSTANT        2'h3

// Sample ticks minus one between updates
`define DVR_PACE_LAST1          2'h0
`define DVR_PACE_LAST2          2'h1
`define DVR_PACE_LAST4          2'h3

// Step sizes in half-dB codes per update
`define DVR_STEP_4DB            8'h08
`define DVR_STEP_2DB            8'h04
`define DVR_STEP_1DB            8'h02
`define DVR_STEP_HALF_DB        8'h01

`endif

// File: dvr_pace.v
// Sample-period pacing counter for the volume ramp updates
`timescale 1ns/10ps
`default_nettype none
`include "dvr_map.vh"

module dvr_pace (
    // Clock, reset and enable
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire       clk_en,
    // Sample period strobe
    input  wire       sample_tick,
    // Pacing control
    input  wire       run,
    input  wire       dir_down,
    input  wire [1:0] rate,
    // Update request
    output wire       update
);

    reg  [1:0] tick_cnt;     // Sample ticks seen since the last update
    reg        last_dir;     // Direction of the ramp being paced
    reg  [1:0] last_cnt;     // Count that completes one update period
    wire       restart;      // Start a fresh period

    // Period length from the rate code
    always @* begin
        case (rate)
            `DVR_RATE_EVERY1: last_cnt = `DVR_PACE_LAST1;
            `DVR_RATE_EVERY2: last_cnt = `DVR_PACE_LAST2;
            `DVR_RATE_EVERY4: last_cnt = `DVR_PACE_LAST4;
            default:          last_cnt = `DVR_PACE_LAST1;
        endcase
    end

    // A direction change starts the period over so a reversal is paced cleanly
    assign restart = !run || (dir_down != last_dir);
    assign update  = run && !restart && sample_tick && (tick_cnt == last_cnt);

    // Tick counter, cleared when idle or on reversal
    always @(posedge sys_clk) begin
        if (!nrst) begin
            tick_cnt <= 2'h0;
            last_dir <= 1'b0;
        end else if (clk_en) begin
            last_dir <= dir_down;
            if (restart || update) begin
                tick_cnt <= 2'h0;
            end else if (sample_tick) begin
                tick_cnt <= tick_cnt + 2'h1;
            end
        end
    end

endmodule
`default_nettype wire

// File: dvr_volume_ctrl.v
// Stereo digital volume ramp controller with its control registers
`timescale 1ns/10ps
`default_nettype none
`include "dvr_map.vh"

module dvr_volume_ctrl (
    // Clock, reset and enable
    input  wire       sys_clk,
    input  wire       nrst,
    input  wire       clk_en,
    // Register access port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Sample period strobe and fault request
    input  wire       sample_tick,
    input  wire       emergency_req,
    // Gain applied to the channels
    output reg  [7:0] gain_code_left,
    output reg  [7:0] gain_code_right,
    output reg  [8:0] gain_half_db,
    output reg        output_muted,
    output reg        ramp_busy,
    // DSP control fields
    output reg  [1:0] processing_rate_select,
    output reg        rom_coefficient_select
);

    // Step size in codes for an increment code
    function [7:0] step_codes;
        input [1:0] inc;
        begin
            case (inc)
                2'h0:    step_codes = `DVR_STEP_4DB;
                2'h1:    step_codes = `DVR_STEP_2DB;
                2'h2:    step_codes = `DVR_STEP_1DB;
                default: step_codes = `DVR_STEP_HALF_DB;
            endcase
        end
    endfunction

    // Software registers
    reg  [7:0] channel_gain_level;     // Programmed target gain code
    reg  [7:0] normal_ramp_config;     // Normal ramp rates and steps
    reg  [7:0] emergency_ramp_config;  // Emergency ramp rate and step
    reg  [2:0] dsp_reserved;           // Writable reserved bits of the DSP control
    reg  [1:0] rate_field;             // Processing rate field
    reg        rom_field;              // Coefficient source bit

    // Ramp state
    reg  [7:0] applied;                // Gain code now applied
    reg  [7:0] next_applied;           // Gain code after this cycle
    reg  [7:0] target;                 // Where the ramp heads
    reg  [1:0] down_ramp_rate;         // Active down rate code
    reg  [1:0] down_ramp_increment;    // Active down step code
    reg  [8:0] sum_down;               // Widened sum for a down step
    reg  [8:0] diff_up;                // Widened difference for an up step
    reg  [7:0] next_rdata;             // Read data before registering
    wire [1:0] up_ramp_rate;           // Normal up rate code
    wire [1:0] up_ramp_increment;      // Normal up step code
    wire       dir_down;               // Target is quieter than applied
    wire       dir_up;                 // Target is louder than applied
    wire [1:0] pace_rate;              // Rate of the ramp in progress
    wire       pace_run;               // Paced ramp in progress
    wire       pace_update;            // One paced update due

    assign up_ramp_rate      = normal_ramp_config[`DVR_UP_RATE_HI:`DVR_UP_RATE_LO];
    assign up_ramp_increment = normal_ramp_config[`DVR_UP_INC_HI:`DVR_UP_INC_LO];

    // Select the ramp profile; a fault request forces a mute target
    always @* begin
        if (emergency_req) begin
            target              = `DVR_CODE_MUTE;
            down_ramp_rate      = emergency_ramp_config[`DVR_DOWN_RATE_HI:`DVR_DOWN_RATE_LO];
            down_ramp_increment = emergency_ramp_config[`DVR_DOWN_INC_HI:`DVR_DOWN_INC_LO];
        end else begin
            target              = channel_gain_level;
            down_ramp_rate      = normal_ramp_config[`DVR_DOWN_RATE_HI:`DVR_DOWN_RATE_LO];
            down_ramp_increment = normal_ramp_config[`DVR_DOWN_INC_HI:`DVR_DOWN_INC_LO];
        end
    end

    // Higher code means lower gain
    assign dir_down  = (target > applied);
    assign dir_up    = (target < applied);
    assign pace_rate = dir_down ? down_ramp_rate : up_ramp_rate;
    assign pace_run  = (dir_down || dir_up) && (pace_rate != `DVR_RATE_INSTANT);

    // Sample-period pacing of the updates
    dvr_pace u_pace (
        .sys_clk     (sys_clk),
        .nrst        (nrst),
        .clk_en      (clk_en),
        .sample_tick (sample_tick),
        .run         (pace_run),
        .dir_down    (dir_down),
        .rate        (pace_rate),
        .update      (pace_update)
    );

    // Next applied gain: instant moves, paced steps, clamp at the target
    always @* begin
        next_applied = applied;
        sum_down     = {1'b0, applied} + {1'b0, step_codes(down_ramp_increment)};
        diff_up      = {1'b0, applied} - {1'b0, step_codes(up_ramp_increment)};
        if (dir_down) begin
            if (down_ramp_rate == `DVR_RATE_INSTANT) begin
                next_applied = target;
            end else if (pace_update) begin
                if (sum_down >= {1'b0, target}) begin
                    next_applied = target;
                end else begin
                    next_applied = sum_down[7:0];
                end
            end
        end else if (dir_up) begin
            if (up_ramp_rate == `DVR_RATE_INSTANT) begin
                next_applied = target;
            end else if (pace_update) begin
                if (diff_up[8] || (diff_up[7:0] <= target)) begin
                    next_applied = target;
                end else begin
                    next_applied = diff_up[7:0];
                end
            end
        end
    end

    // Applied gain and the outputs derived from it
    always @(posedge sys_clk) begin
        if (!nrst) begin
            applied         <= `DVR_RST_GAIN_LEVEL;
            gain_code_left  <= `DVR_RST_GAIN_LEVEL;
            gain_code_right <= `DVR_RST_GAIN_LEVEL;
            gain_half_db    <= 9'h000;
            output_muted    <= 1'b0;
            ramp_busy       <= 1'b0;
        end else if (clk_en) begin
            applied         <= next_applied;
            gain_code_left  <= next_applied;
            gain_code_right <= next_applied;
            // Gain in signed half-dB, unity code reads zero
            gain_half_db    <= `DVR_UNITY_HALF_DB - {1'b0, next_applied};
            output_muted    <= (next_applied == `DVR_CODE_MUTE);
            ramp_busy       <= (next_applied != target);
        end
    end

    // Register writes; unmapped addresses are ignored
    always @(posedge sys_clk) begin
        if (!nrst) begin
            channel_gain_level    <= `DVR_RST_GAIN_LEVEL;
            normal_ramp_config    <= `DVR_RST_NORMAL_RAMP;
            emergency_ramp_config <= `DVR_RST_EMERG_RAMP;
            dsp_reserved          <= `DVR_RST_DSP_RSV;
            rate_field            <= `DVR_RST_DSP_RATE;
            rom_field             <= `DVR_RST_DSP_ROM;
        end else if (clk_en && reg_wr) begin
            case (reg_addr)
                `DVR_OFF_GAIN_LEVEL:  channel_gain_level    <= reg_wdata;
                `DVR_OFF_NORMAL_RAMP: normal_ramp_config    <= reg_wdata;
                `DVR_OFF_EMERG_RAMP:  emergency_ramp_config <= reg_wdata;
                `DVR_OFF_DSP_CTRL: begin
                    dsp_reserved <= reg_wdata[`DVR_DSP_RSV_HI:`DVR_DSP_RSV_LO];
                    rate_field   <= reg_wdata[`DVR_DSP_RATE_HI:`DVR_DSP_RATE_LO];
                    rom_field    <= reg_wdata[`DVR_DSP_ROM_BIT];
                end
                default: begin
                    // Writes elsewhere have no effect
                end
            endcase
        end
    end

    // DSP control outputs follow their fields one cycle later
    always @(posedge sys_clk) begin
        if (!nrst) begin
            processing_rate_select <= `DVR_RST_DSP_RATE;
            rom_coefficient_select <= `DVR_RST_DSP_ROM;
        end else if (clk_en) begin
            processing_rate_select <= rate_field;
            rom_coefficient_select <= rom_field;
        end
    end

    // Read multiplexer; read-only reserved bits and unmapped reads give zero
    always @* begin
        case (reg_addr)
            `DVR_OFF_GAIN_LEVEL:   next_rdata = channel_gain_level;
            `DVR_OFF_APPLIED_GAIN: next_rdata = applied;
            `DVR_OFF_NORMAL_RAMP:  next_rdata = normal_ramp_config;
            `DVR_OFF_EMERG_RAMP:   next_rdata = emergency_ramp_config;
            `DVR_OFF_DSP_CTRL:     next_rdata = {dsp_reserved, rate_field, 2'h0, rom_field};
            default:               next_rdata = 8'h00;
        endcase
    end

    // Read data register, updated on a read strobe
    always @(posedge sys_clk) begin
        if (!nrst) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= next_rdata;
        end
    end

endmodule
`default_nettype wire

// File: tb.sv
// Self-checking bench for the volume ramp block
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        sys_clk = 0;       // 50 MHz clock
    logic        nrst = 0;          // Sync reset, active low
    logic        clk_en = 1;        // Clock enable
    logic [7:0]  reg_addr = 0;      // Register offset
    logic [7:0]  reg_wdata = 0;     // Write data
    logic        reg_wr = 0;        // Write strobe
    logic        reg_rd = 0;        // Read strobe
    logic        sample_tick = 0;   // Sample period strobe
    logic        emergency_req = 0; // Fault request
    wire  [7:0]  reg_rdata;         // Read data
    wire  [7:0]  gain_l;            // Applied gain code
    wire         busy;              // Ramp still heading for its target
    int          fails = 0;         // Mismatch count
    int          n_tests = 0;       // Comparison count
    int          ticks = 0;         // Sample ticks sent
    integer      seed = 32'hdefdcfbb;
    logic [31:0] exp_g [$];         // Expected tick, busy and gain notes
    logic [7:0]  exp_r [$];         // Expected read data
    logic [7:0]  cur = 8'h30;       // Modelled gain code
    logic [7:0]  last_g = 8'h30;    // Gain seen last cycle
    logic        rd_q = 0;          // A read was taken
    logic        run_on = 0;        // Monitor enabled
    logic [15:0] rst_tab [6] = '{16'h4c30, 16'h4e33, 16'h4f30, 16'h4601, 16'h4d30, 16'h0000};
    // Clock
    always #10 sys_clk = ~sys_clk;
    dvr_volume_ctrl u_dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .sample_tick(sample_tick), .emergency_req(emergency_req), .gain_code_left(gain_l),
        .gain_code_right(), .gain_half_db(), .output_muted(), .ramp_busy(busy),
        .processing_rate_select(), .rom_coefficient_select());
    // Compare tasks, one per result kind
    task automatic check_rd(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t read %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_gain(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t tick_gain %h exp %h", $time, got, exp);
        end
    endtask
    // Note reads taken
    always @(posedge sys_clk) rd_q <= reg_rd && clk_en;
    // Monitor: pop the oldest note as each result appears
    always @(negedge sys_clk) begin
        if (run_on && rd_q) check_rd(reg_rdata, exp_r.pop_front());
        if (run_on && gain_l !== last_g) check_gain({ticks[22:0], busy, gain_l}, exp_g.pop_front());
        last_g <= gain_l;
    end
    // Register bus cycles
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_r.push_back(e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
    endtask
    // Sample strobes, two cycles apart
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            sample_tick <= 1'b1;
            @(posedge sys_clk);
            sample_tick <= 1'b0;
            ticks++;
        end
    endtask
    // New target by write or fault toggle; notes each step with its tick
    task automatic move(input logic [7:0] tgt, input logic [1:0] rate, input logic [1:0] st, input logic emg);
        int k;
        int t0;
        logic [7:0] sz;
        sz = 8'h08 >> st;
        if (rate == 2'h3) exp_g.push_back({ticks[22:0], 1'b0, tgt});
        if (emg) begin
            @(posedge sys_clk);
            emergency_req <= !emergency_req;
        end else wr(8'h4c, tgt);
        repeat (3) @(posedge sys_clk);
        t0 = ticks;
        k = 0;
        if (rate == 2'h3) cur = tgt;
        while (cur != tgt) begin
            k++;
            if (cur < tgt) cur = (tgt - cur > sz) ? cur + sz : tgt;
            else cur = (cur - tgt > sz) ? cur - sz : tgt;
            exp_g.push_back({t0[22:0] + 23'(k << rate), (cur != tgt), cur});
        end
        tick(k << rate);
    endtask
    // Main sequence
    initial begin
        int r;
        int s;
        int k;
        int d;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        run_on = 1;
        foreach (rst_tab[i]) rd(rst_tab[i][15:8], rst_tab[i][7:0]);
        wr(8'h4d, 8'h00);
        rd(8'h4d, 8'h30);
        for (r = 0; r < 4; r++) begin
            d = $random(seed);
            d[4:3] = r[1:0];
            d[0] = r[0];
            wr(8'h46, d[7:0]);
            rd(8'h46, d[7:0] & 8'hf9);
        end
        $display("test registers done");
        for (d = 0; d < 24; d++) begin
            r = d % 3;
            s = (d / 3) % 4;
            k = 1 + ($random(seed) & 31);
            if (d < 12) begin
                wr(8'h4e, {r[1:0], s[1:0], 4'hc});
                move(8'h30 + k[7:0], r[1:0], s[1:0], 1'b0);
                move(8'h30, 2'h3, 2'h0, 1'b0);
            end else begin
                wr(8'h4e, {4'hc, r[1:0], s[1:0]});
                move(8'h30 + k[7:0], 2'h3, 2'h0, 1'b0);
                move(8'h30, r[1:0], s[1:0], 1'b0);
            end
        end
        $display("test ramps done");
        wr(8'h4e, 8'h0c);
        move(8'hff, 2'h0, 2'h0, 1'b0);
        move(8'h30, 2'h3, 2'h0, 1'b0);
        $display("test mute done");
        for (r = 0; r < 4; r++) begin
            s = 3 - r;
            wr(8'h4f, {r[1:0], s[1:0], 4'ha});
            rd(8'h4f, {r[1:0], s[1:0], 4'ha});
            move(8'hff, r[1:0], s[1:0], 1'b1);
            move(8'h30, 2'h3, 2'h0, 1'b1);
        end
        $display("test emergency done");
        @(posedge sys_clk);
        clk_en <= 1'b0;
        wr(8'h4c, 8'h55);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd(8'h4c, 8'h30);
        $display("test freeze done");
        repeat (4) @(posedge sys_clk);
        complete_run();
    end
    // Watchdog sized well beyond the expected run
    initial begin
        #(20 * 60000);
        fails++;
        complete_run();
    end
    // Verdict and end of run
    task automatic complete_run();
        if (exp_g.size() != 0 || exp_r.size() != 0) fails++;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
endmodule
`default_nettype wire
